//--- src/cbu_pkg.sv
// Shared constants and types for the conditional skip and branch unit
`default_nettype none
package cbu_pkg;
    // Operand field widths
    localparam int unsigned OFF_W    = 7;
    localparam int unsigned BIT_W    = 3;
    localparam int unsigned FLAG_W   = 8;
    localparam int unsigned IO_W     = 8;

    // Program counter steps, in words
    localparam int unsigned STEP_SEQ      = 1;
    localparam int unsigned STEP_SKIP_ONE = 2;
    localparam int unsigned STEP_SKIP_TWO = 3;
    localparam int unsigned STEP_BRANCH   = 1;

    // Operation select from the decoder
    typedef enum logic [2:0] {
        CBU_SKIP_ON_IO_BIT_ONE       = 3'h0,
        CBU_BRANCH_ON_STATUS_BIT_ONE = 3'h1,
        CBU_BRANCH_ON_STATUS_BIT_ZERO = 3'h2,
        CBU_BRANCH_WHEN_EQUAL        = 3'h3,
        CBU_BRANCH_WHEN_UNEQUAL      = 3'h4,
        CBU_BRANCH_BORROW_OUT_ONE    = 3'h5,
        CBU_BRANCH_BORROW_OUT_ZERO   = 3'h6,
        CBU_BRANCH_UNSIGNED_NOT_LOWER = 3'h7
    } cbu_op_t;

    // Sequencer states, Gray along idle, two-left, one-left
    typedef enum logic [1:0] {
        CBU_IDLE     = 2'h0,
        CBU_TWO_LEFT = 2'h1,
        CBU_ONE_LEFT = 2'h3
    } cbu_state_t;

    // Reset values
    localparam logic [1:0] RST_STATE = 2'h0;
endpackage
`default_nettype wire

//--- src/cbu_cond.sv
// Condition evaluator for skip and branch operations
`default_nettype none
module cbu_cond #(
    parameter int unsigned ZERO_POS   = 1,   // Equal-result flag position in status word
    parameter int unsigned BORROW_POS = 0    // Borrow-out flag position in status word
) (
    input  wire cbu_pkg::cbu_op_t            op,        // Operation select
    input  wire logic [cbu_pkg::BIT_W-1:0]   bit_sel,   // Bit number for bit tests
    input  wire logic [cbu_pkg::FLAG_W-1:0]  flags,     // Status flag word
    input  wire logic [cbu_pkg::IO_W-1:0]    io_value,  // Addressed I/O register
    output logic                             cond       // Condition holds
);
    import cbu_pkg::*;

    logic sel_flag;
    logic sel_io;
    logic zero_flag;
    logic borrow_flag;

    // Bit picks; flags are read only, never written here
    assign sel_flag    = flags[bit_sel];
    assign sel_io      = io_value[bit_sel];
    assign zero_flag   = flags[ZERO_POS];
    assign borrow_flag = flags[BORROW_POS];

    // Per-operation test
    always_comb begin
        cond = 1'b0;
        unique case (op)
            CBU_SKIP_ON_IO_BIT_ONE:        cond = sel_io;          // [RULE1]
            CBU_BRANCH_ON_STATUS_BIT_ONE:  cond = sel_flag;        // [RULE3]
            CBU_BRANCH_ON_STATUS_BIT_ZERO: cond = ~sel_flag;       // [RULE4]
            CBU_BRANCH_WHEN_EQUAL:         cond = zero_flag;       // [RULE5]
            CBU_BRANCH_WHEN_UNEQUAL:       cond = ~zero_flag;      // [RULE6]
            CBU_BRANCH_BORROW_OUT_ONE:     cond = borrow_flag;     // [RULE7]
            CBU_BRANCH_BORROW_OUT_ZERO:    cond = ~borrow_flag;    // [RULE8]
            CBU_BRANCH_UNSIGNED_NOT_LOWER: cond = ~borrow_flag;    // [RULE9]
        endcase
    end
endmodule
`default_nettype wire

//--- src/cbu_unit.sv
// Conditional skip and branch execution unit, top level
//
// Notes on behaviour
// RULE1 - A skip on a set I/O bit advances the program counter by two or three words by the skipped length.
// RULE2 - The I/O-bit skip takes one cycle without skip, two over a one-word and three over a two-word instruction.
// RULE3 - Branch on status bit one loads program counter plus signed offset plus one when that bit is one.
// RULE4 - Branch on status bit zero loads program counter plus offset plus one when that bit is zero.
// RULE5 - Branch when equal takes offset plus one only when the equal-result flag is one.
// RULE6 - Branch when unequal takes offset plus one only when the equal-result flag is zero.
// RULE7 - Branch on borrow-out one takes offset plus one only when the borrow-out flag is one.
// RULE8 - Branch on borrow-out zero takes offset plus one only when the borrow-out flag is zero.
// RULE9 - Unsigned not-lower branch behaves exactly like the borrow-out zero branch.
// RULE10 - No operation here ever writes any status flag.
// RULE11 - A branch takes one cycle when not taken and two when taken, offset being signed words.
`default_nettype none
module cbu_unit #(
    parameter int unsigned PC_W       = 16,  // Program counter width in bits
    parameter int unsigned ZERO_POS   = 1,   // Equal-result flag position
    parameter int unsigned BORROW_POS = 0    // Borrow-out flag position
) (
    input  wire logic                          clk,            // Core clock
    input  wire logic                          rst,            // Async reset, active high
    input  wire logic                          instr_valid,    // Operation offered
    input  wire cbu_pkg::cbu_op_t              instr_op,       // Operation select
    input  wire logic [cbu_pkg::BIT_W-1:0]     instr_bit,      // Bit number
    input  wire logic [cbu_pkg::OFF_W-1:0]     instr_offset,   // Signed word offset
    input  wire logic                          next_two_word,  // Following instr is two words
    input  wire logic [PC_W-1:0]               pc_in,          // Current program counter
    input  wire logic [cbu_pkg::FLAG_W-1:0]    status_flag_word, // Status flags
    input  wire logic [cbu_pkg::IO_W-1:0]      io_reg_value,   // Addressed I/O register
    output logic                               instr_ready,    // Free to take an operation
    output logic                               done,           // Operation finished, pulse
    output logic [PC_W-1:0]                    pc_out,         // New program counter
    output logic                               branch_taken,   // Skip or branch happened
    output logic                               status_write    // Flag write strobe, held low
);
    import cbu_pkg::*;

    cbu_state_t      state;
    cbu_state_t      next_state;
    logic            done_q;
    logic            next_done;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] next_pc;
    logic            taken_q;
    logic            next_taken;
    logic            cond;
    logic            accept;
    logic            is_skip;
    logic [PC_W-1:0] off_ext;
    logic [PC_W-1:0] pc_seq;
    logic [PC_W-1:0] pc_skip;
    logic [PC_W-1:0] pc_branch;

    cbu_cond #(
        .ZERO_POS   (ZERO_POS),
        .BORROW_POS (BORROW_POS)
    ) u_cond (
        .op       (instr_op),
        .bit_sel  (instr_bit),
        .flags    (status_flag_word),
        .io_value (io_reg_value),
        .cond     (cond)
    );

    // Handshake
    assign instr_ready = (state == CBU_IDLE);
    assign accept      = instr_valid & instr_ready;
    assign is_skip     = (instr_op == CBU_SKIP_ON_IO_BIT_ONE);

    // Target arithmetic; sign extension keeps backward branches correct
    assign off_ext   = {{(PC_W-OFF_W){instr_offset[OFF_W-1]}}, instr_offset};  // [RULE11]
    assign pc_seq    = pc_in + PC_W'(STEP_SEQ);
    assign pc_skip   = pc_in + (next_two_word ? PC_W'(STEP_SKIP_TWO) : PC_W'(STEP_SKIP_ONE));  // [RULE1]
    assign pc_branch = pc_in + off_ext + PC_W'(STEP_BRANCH);  // [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9]

    // Sequencer and result next values
    always_comb begin
        next_state = state;
        next_done  = 1'b0;
        next_pc    = pc_q;
        next_taken = taken_q;
        unique case (state)
            CBU_IDLE: begin
                if (accept) begin
                    next_taken = cond;
                    if (!cond) begin
                        next_pc   = pc_seq;             // One cycle, falls through [RULE2] [RULE11]
                        next_done = 1'b1;
                    end else if (is_skip) begin
                        next_pc    = pc_skip;
                        next_state = next_two_word ? CBU_TWO_LEFT : CBU_ONE_LEFT;  // [RULE2]
                    end else begin
                        next_pc    = pc_branch;
                        next_state = CBU_ONE_LEFT;      // Taken branch costs two [RULE11]
                    end
                end
            end
            CBU_TWO_LEFT: begin
                next_state = CBU_ONE_LEFT;
            end
            CBU_ONE_LEFT: begin
                next_state = CBU_IDLE;
                next_done  = 1'b1;
            end
            default: begin
                next_state = CBU_IDLE;                  // Unused code recovers to idle
            end
        endcase
    end

    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state   <= cbu_state_t'(RST_STATE);
            done_q  <= 1'b0;
            pc_q    <= '0;
            taken_q <= 1'b0;
        end else begin
            state   <= next_state;
            done_q  <= next_done;
            pc_q    <= next_pc;
            taken_q <= next_taken;
        end
    end

    // Outputs from flops; flag writes never issued
    assign done         = done_q;
    assign pc_out       = pc_q;
    assign branch_taken = taken_q;
    assign status_write = 1'b0;  // [RULE10]

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_take_skip;
        accept && is_skip && cond;
    endsequence

    sequence s_take_branch;
        accept && !is_skip && cond;
    endsequence

    sequence s_busy_two;
        !instr_ready [*2];
    endsequence

    sequence s_taken_end;
        !done ##1 (done && branch_taken);
    endsequence

    chk_skip_three_words: assert property (  // [RULE1]
        s_take_skip and next_two_word |-> ##3 (done && pc_out == $past(pc_in, 3) + PC_W'(STEP_SKIP_TWO)))
        else $error("skip over two-word instruction wrong target");

    chk_skip_two_words: assert property (  // [RULE1]
        s_take_skip and !next_two_word |-> ##2 (done && pc_out == $past(pc_in, 2) + PC_W'(STEP_SKIP_ONE)))
        else $error("skip over one-word instruction wrong target");

    chk_skip_three_cycles: assert property (  // [RULE2]
        s_take_skip and next_two_word |-> ##1 s_busy_two ##1 (instr_ready && done))
        else $error("long skip not three cycles");

    chk_skip_one_cycle: assert property (  // [RULE2]
        accept && is_skip && !cond |-> ##1 (done && instr_ready && !branch_taken))
        else $error("no-skip case not one cycle");

    chk_branch_target: assert property (  // [RULE3]
        s_take_branch |-> ##1 !done ##1 (done && branch_taken &&
            pc_out == $past(pc_in, 2) + $past(off_ext, 2) + PC_W'(STEP_BRANCH)))
        else $error("taken branch wrong target or timing");

    // Picks held against the raw inputs, so a slip in the evaluator shows
    chk_skip_io_sel: assert property (  // [RULE1]
        accept && instr_op == CBU_SKIP_ON_IO_BIT_ONE |-> cond == io_reg_value[instr_bit])
        else $error("skip test does not follow the io bit");

    chk_status_one_sel: assert property (  // [RULE3]
        accept && instr_op == CBU_BRANCH_ON_STATUS_BIT_ONE |-> cond == status_flag_word[instr_bit])
        else $error("status-bit-one test wrong");

    chk_status_zero_sel: assert property (  // [RULE4]
        accept && instr_op == CBU_BRANCH_ON_STATUS_BIT_ZERO |-> cond == !status_flag_word[instr_bit])
        else $error("status-bit-zero test inverted");

    chk_equal_flag: assert property (  // [RULE5]
        accept && instr_op == CBU_BRANCH_WHEN_EQUAL |-> cond == status_flag_word[ZERO_POS])
        else $error("equal branch condition wrong");

    chk_unequal_flag: assert property (  // [RULE6]
        accept && instr_op == CBU_BRANCH_WHEN_UNEQUAL |-> cond == !status_flag_word[ZERO_POS])
        else $error("unequal branch condition wrong");

    chk_unequal_taken: assert property (  // [RULE6]
        accept && instr_op == CBU_BRANCH_WHEN_UNEQUAL && !status_flag_word[ZERO_POS] |=> s_taken_end)
        else $error("unequal branch not taken in two cycles");

    chk_borrow_one: assert property (  // [RULE7]
        accept && instr_op == CBU_BRANCH_BORROW_OUT_ONE |-> cond == status_flag_word[BORROW_POS])
        else $error("borrow-one branch condition wrong");

    chk_borrow_one_taken: assert property (  // [RULE7]
        accept && instr_op == CBU_BRANCH_BORROW_OUT_ONE && status_flag_word[BORROW_POS] |=> s_taken_end)
        else $error("borrow-one branch not taken in two cycles");

    chk_borrow_zero: assert property (  // [RULE8]
        accept && instr_op == CBU_BRANCH_BORROW_OUT_ZERO |-> cond == !status_flag_word[BORROW_POS])
        else $error("borrow-zero branch condition wrong");

    chk_not_lower_same: assert property (  // [RULE9]
        accept && instr_op == CBU_BRANCH_UNSIGNED_NOT_LOWER |-> cond == !status_flag_word[BORROW_POS])
        else $error("not-lower branch differs from borrow-zero");

    chk_not_lower_taken: assert property (  // [RULE9]
        accept && instr_op == CBU_BRANCH_UNSIGNED_NOT_LOWER && !status_flag_word[BORROW_POS] |=> s_taken_end)
        else $error("not-lower branch not taken in two cycles");

    chk_no_flag_write: assert property (  // [RULE10]
        !status_write)
        else $error("flag write strobe raised");

    chk_fall_through: assert property (  // [RULE11]
        accept && !cond |=> done && instr_ready && pc_out == $past(pc_in) + PC_W'(STEP_SEQ))
        else $error("untaken branch not one cycle or wrong pc");

    chk_taken_busy: assert property (  // [RULE11]
        s_take_branch |=> !instr_ready ##1 instr_ready)
        else $error("taken branch busy time wrong");
endmodule
`default_nettype wire

//--- bench/cbu_unit_tb.sv
// Self-checking random testbench for the conditional skip and branch unit
`default_nettype none
module cbu_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cbu_pkg::*;

    logic                clk;
    logic                rst;
    logic                instr_valid;
    cbu_op_t             instr_op;
    logic [BIT_W-1:0]    instr_bit;
    logic [OFF_W-1:0]    instr_offset;
    logic                next_two_word;
    logic [15:0]         pc_in;
    logic [FLAG_W-1:0]   status_flag_word;
    logic [IO_W-1:0]     io_reg_value;
    logic                instr_ready;
    logic                done;
    logic [15:0]         pc_out;
    logic                branch_taken;
    logic                status_write;
    int                  fail_count;
    int                  checks;

    cbu_unit #(.PC_W(16), .ZERO_POS(1), .BORROW_POS(0)) cbu_unit_i (
        .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_bit(instr_bit), .instr_offset(instr_offset), .next_two_word(next_two_word),
        .pc_in(pc_in), .status_flag_word(status_flag_word), .io_reg_value(io_reg_value),
        .instr_ready(instr_ready), .done(done), .pc_out(pc_out),
        .branch_taken(branch_taken), .status_write(status_write)
    );

    // 125 MHz core clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Verdict, shared by the main sequence and the watchdog
    task automatic summarize();
        if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Four-state compare so an unknown never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Condition the operation should act on
    function automatic logic exp_cond(cbu_op_t op, logic [2:0] b, logic [7:0] f, logic [7:0] io);
        case (op)
            CBU_SKIP_ON_IO_BIT_ONE:        return io[b];
            CBU_BRANCH_ON_STATUS_BIT_ONE:  return f[b];
            CBU_BRANCH_ON_STATUS_BIT_ZERO: return !f[b];
            CBU_BRANCH_WHEN_EQUAL:         return f[1];
            CBU_BRANCH_WHEN_UNEQUAL:       return !f[1];
            CBU_BRANCH_BORROW_OUT_ONE:     return f[0];
            default:                       return !f[0];
        endcase
    endfunction

    // Offer one operation, scribble refused requests while busy, then compare
    task automatic run_op(cbu_op_t op, logic [2:0] b, logic [6:0] k, logic two,
                          logic [15:0] pc, logic [7:0] f, logic [7:0] io);
        logic        c;
        logic [15:0] pc_x;
        int          cyc_x;
        int          n;
        c = exp_cond(op, b, f, io);
        pc_x = pc + 16'h1;
        cyc_x = 1;
        if (c && op == CBU_SKIP_ON_IO_BIT_ONE) begin
            pc_x = two ? pc + 16'h3 : pc + 16'h2;
            cyc_x = two ? 3 : 2;
        end else if (c) begin
            pc_x = pc + {{9{k[6]}}, k} + 16'h1;
            cyc_x = 2;
        end
        instr_valid = 1'b1;
        instr_op = op;
        instr_bit = b;
        instr_offset = k;
        next_two_word = two;
        pc_in = pc;
        status_flag_word = f;
        io_reg_value = io;
        @(posedge clk);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            check(32'(status_write), 32'h0);
            if (done !== 1'b1) begin
                check(32'(instr_ready), 32'h0);
                instr_op = cbu_op_t'($urandom_range(7));
                pc_in = 16'($urandom);
                status_flag_word = 8'($urandom);
                io_reg_value = 8'($urandom);
            end
        end while (done !== 1'b1 && n < 6);
        check(32'(n), 32'(cyc_x));
        check(32'(pc_out), 32'(pc_x));
        check(32'(branch_taken), 32'(c));
        check(32'(instr_ready), 32'h1);
    endtask

    // Main sequence: corners first, then random traffic back to back
    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_op = CBU_SKIP_ON_IO_BIT_ONE;
        instr_bit = 3'h0;
        instr_offset = 7'h00;
        next_two_word = 1'b0;
        pc_in = 16'h0000;
        status_flag_word = 8'h00;
        io_reg_value = 8'h00;
        fail_count = 0;
        checks = 0;
        void'($urandom(48));
        repeat (5) @(negedge clk);
        check(32'(status_write), 32'h0);
        check(32'(instr_ready), 32'h1);
        check(32'(done), 32'h0);
        rst = 1'b0;
        // Every operation both ways, extreme offsets, counter wrap
        for (int o = 0; o < 8; o++) begin
            for (int v = 0; v < 2; v++) begin
                run_op(cbu_op_t'(o), 3'(o), v ? 7'h40 : 7'h3f, 1'(v), v ? 16'h0000 : 16'hffff,
                       v ? 8'hff : 8'h00, v ? 8'hff : 8'h00);
            end
        end
        // Skip over a two-word instruction across the wrap
        run_op(CBU_SKIP_ON_IO_BIT_ONE, 3'h7, 7'h00, 1'b1, 16'hfffe, 8'h00, 8'h80);
        repeat (400) begin
            run_op(cbu_op_t'($urandom_range(7)), 3'($urandom), 7'($urandom), 1'($urandom),
                   16'($urandom), 8'($urandom), 8'($urandom));
        end
        instr_valid = 1'b0;
        repeat (3) @(negedge clk);
        summarize();
    end

    // Watchdog, far beyond the at most about 1260 cycles the run needs
    initial begin
        #(8 * 20000);
        fail_count++;
        summarize();
    end
endmodule
`default_nettype wire
